// *** hdl/byte_alu_pkg.sv ***
// constants, encodings and carrier types of the byte arithmetic unit
// assumes: one master on an ahb-lite bus, one clock, no imports anywhere
package byte_alu_pkg;

    localparam int unsigned DATA_W    = 8;
    localparam int unsigned BYTE_MSB  = 7;
    localparam int unsigned NIB_W     = 4;
    localparam int unsigned OP_W      = 5;
    localparam int unsigned FLAG_W    = 6;

    // register byte addresses, low byte of haddr
    localparam logic [7:0] REG_DEST    = 8'h00;
    localparam logic [7:0] REG_SRC     = 8'h04;
    localparam logic [7:0] REG_IMM     = 8'h08;
    localparam logic [7:0] REG_WORD_HI = 8'h0C;
    localparam logic [7:0] REG_FLAGS   = 8'h10;
    localparam logic [7:0] REG_CMD     = 8'h14;

    localparam int unsigned CMD_BUSY_BIT = 8;

    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [7:0] BYTE_ONE      = 8'h01;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;

    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TRANS_SEQ    = 2'h3;
    localparam logic [2:0] SIZE_WORD    = 3'h2;

    typedef enum logic [OP_W-1:0] {
        OP_SUM             = 5'h00,
        OP_SUM_CARRY       = 5'h01,
        OP_DIFF            = 5'h02,
        OP_DIFF_BORROW     = 5'h03,
        OP_DIFF_IMM        = 5'h04,
        OP_DIFF_IMM_BORROW = 5'h05,
        OP_WORD_ADD_IMM    = 5'h06,
        OP_WORD_MINUS_IMM  = 5'h07,
        OP_AND             = 5'h08,
        OP_AND_IMM         = 5'h09,
        OP_OR              = 5'h0A,
        OP_OR_IMM          = 5'h0B,
        OP_XOR             = 5'h0C,
        OP_COMPLEMENT      = 5'h0D,
        OP_TWOS_COMPLEMENT = 5'h0E,
        OP_MASK_SET        = 5'h0F,
        OP_MASK_CLEAR      = 5'h10,
        OP_PLUS_ONE        = 5'h11,
        OP_MINUS_ONE       = 5'h12
    } opcode_t;

    localparam logic [OP_W-1:0] OP_LAST = 5'h12;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_EXEC,
        PH_WORD_HI
    } phase_t;

    // status flags, bit 0 carry up to bit 5 half carry
    typedef struct packed {
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } flags_t;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       h;
        logic       v;
    } alu_out_t;

endpackage

// *** hdl/byte_arith_logic_unit.sv ***
// byte arithmetic and logic unit behind an ahb-lite register slave
// assumes: single-word transfers, hready from this slave only
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
module byte_arith_logic_unit #(
    parameter int unsigned WORD_IMM_W = 6
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    // whole state of the unit, registered in one place
    typedef struct packed {
        byte_alu_pkg::phase_t  phase;
        byte_alu_pkg::opcode_t op;
        logic [7:0]            dest;
        logic [7:0]            src;
        logic [7:0]            imm;
        logic [7:0]            wordHi;
        byte_alu_pkg::flags_t  flags;
        logic                  wCarry;
        logic                  wLowZero;
        logic                  wPend;
        logic [7:0]            wAddr;
        logic                  rPend;
        logic [7:0]            rAddr;
        logic [31:0]           rdata;
        logic                  ready;
        logic                  resp;
    } state_t;

    localparam state_t RESET_STATE = '{
        phase:    byte_alu_pkg::PH_IDLE,
        op:       byte_alu_pkg::OP_SUM,
        dest:     byte_alu_pkg::BYTE_ZERO,
        src:      byte_alu_pkg::BYTE_ZERO,
        imm:      byte_alu_pkg::BYTE_ZERO,
        wordHi:   byte_alu_pkg::BYTE_ZERO,
        flags:    6'h00,
        wCarry:   1'b0,
        wLowZero: 1'b0,
        wPend:    1'b0,
        wAddr:    byte_alu_pkg::BYTE_ZERO,
        rPend:    1'b0,
        rAddr:    byte_alu_pkg::BYTE_ZERO,
        rdata:    32'h0000_0000,
        ready:    1'b1,
        resp:     1'b0
    };

    state_t s_q;
    state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // add or subtract with carry in; carry, half carry and overflow out
    function automatic byte_alu_pkg::alu_out_t arith8(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic       cin,
        input logic       sub
    );
        logic [4:0] lo;
        logic [8:0] full;
        byte_alu_pkg::alu_out_t o;
        if (sub) begin
            lo   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        end else begin
            lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        end
        o.res = full[byte_alu_pkg::BYTE_MSB:0];
        o.c   = full[byte_alu_pkg::DATA_W];
        o.h   = lo[byte_alu_pkg::NIB_W];
        if (sub) begin
            o.v = (a[byte_alu_pkg::BYTE_MSB] != b[byte_alu_pkg::BYTE_MSB])
                && (o.res[byte_alu_pkg::BYTE_MSB]
                    != a[byte_alu_pkg::BYTE_MSB]);
        end else begin
            o.v = (a[byte_alu_pkg::BYTE_MSB] == b[byte_alu_pkg::BYTE_MSB])
                && (o.res[byte_alu_pkg::BYTE_MSB]
                    != a[byte_alu_pkg::BYTE_MSB]);
        end
        return o;
    endfunction

    // zero, negative and sign from a result byte and its overflow
    function automatic byte_alu_pkg::flags_t znvs(
        input byte_alu_pkg::flags_t f,
        input logic [7:0]           r,
        input logic                 v
    );
        byte_alu_pkg::flags_t o;
        o   = f;
        o.z = (r == byte_alu_pkg::BYTE_ZERO);
        o.n = r[byte_alu_pkg::BYTE_MSB];
        o.v = v;
        o.s = o.n ^ v;
        return o;
    endfunction

    // borrow forms also take the carry flag in
    function automatic logic takesBorrow(
        input byte_alu_pkg::opcode_t op
    );
        return op == byte_alu_pkg::OP_DIFF_BORROW
            || op == byte_alu_pkg::OP_DIFF_IMM_BORROW;
    endfunction

    // immediate forms read the constant instead of the source
    function automatic logic takesImm(
        input byte_alu_pkg::opcode_t op
    );
        return op == byte_alu_pkg::OP_DIFF_IMM
            || op == byte_alu_pkg::OP_DIFF_IMM_BORROW;
    endfunction

    // one register as a word, zero outside the map
    function automatic logic [31:0] readMux(
        input state_t     s,
        input logic [7:0] a
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            byte_alu_pkg::REG_DEST:    d[7:0] = s.dest;
            byte_alu_pkg::REG_SRC:     d[7:0] = s.src;
            byte_alu_pkg::REG_IMM:     d[7:0] = s.imm;
            byte_alu_pkg::REG_WORD_HI: d[7:0] = s.wordHi;
            byte_alu_pkg::REG_FLAGS:
                d[byte_alu_pkg::FLAG_W-1:0] = s.flags;
            byte_alu_pkg::REG_CMD: begin
                d[byte_alu_pkg::OP_W-1:0] = s.op;
                d[byte_alu_pkg::CMD_BUSY_BIT] =
                    (s.phase != byte_alu_pkg::PH_IDLE);
            end
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic                   addrPhase;
    logic                   busy;
    logic [7:0]             wByte;
    logic [7:0]             wordImm;
    byte_alu_pkg::alu_out_t ar;
    byte_alu_pkg::flags_t   f;

    always_comb begin
        s_d     = s_q;
        busy    = (s_q.phase != byte_alu_pkg::PH_IDLE);
        wByte   = hwdata[7:0];
        wordImm = s_q.imm & 8'((1 << WORD_IMM_W) - 1);
        ar      = arith8(s_q.dest, s_q.src, 1'b0, 1'b0);
        f       = s_q.flags;
        addrPhase = hsel && hready
            && (htrans == byte_alu_pkg::TRANS_NONSEQ
                || htrans == byte_alu_pkg::TRANS_SEQ)
            && hsize == byte_alu_pkg::SIZE_WORD;

        // bus: address phase capture
        s_d.wPend = 1'b0;
        if (addrPhase && hwrite) begin
            s_d.wPend = 1'b1;
            s_d.wAddr = haddr[7:0];
        end

        // bus: reads wait one cycle so earlier writes are visible
        s_d.rPend = 1'b0;
        s_d.ready = 1'b1;
        if (addrPhase && !hwrite) begin
            s_d.rPend = 1'b1;
            s_d.rAddr = haddr[7:0];
            s_d.ready = 1'b0;
        end
        if (s_q.rPend) begin
            s_d.rdata = readMux(s_q, s_q.rAddr);
        end

        // execution
        unique case (s_q.phase)
            byte_alu_pkg::PH_IDLE: begin
                // waits for a command write
            end
            byte_alu_pkg::PH_EXEC: begin
                s_d.phase = byte_alu_pkg::PH_IDLE;
                unique case (s_q.op)
                    byte_alu_pkg::OP_SUM, byte_alu_pkg::OP_SUM_CARRY: begin
                        ar = arith8(s_q.dest, s_q.src,
                            (s_q.op == byte_alu_pkg::OP_SUM_CARRY)
                            && s_q.flags.c, 1'b0);
                        f   = znvs(s_q.flags, ar.res, ar.v);
                        f.c = ar.c;
                        f.h = ar.h;
                    end
                    byte_alu_pkg::OP_DIFF, byte_alu_pkg::OP_DIFF_BORROW,
                    byte_alu_pkg::OP_DIFF_IMM,
                    byte_alu_pkg::OP_DIFF_IMM_BORROW: begin
                        ar = arith8(s_q.dest,
                            takesImm(s_q.op) ? s_q.imm : s_q.src,
                            takesBorrow(s_q.op) && s_q.flags.c,
                            1'b1);
                        f   = znvs(s_q.flags, ar.res, ar.v);
                        f.c = ar.c;
                        f.h = ar.h;
                        // borrow forms only keep or clear zero
                        if (takesBorrow(s_q.op)) begin
                            f.z = f.z && s_q.flags.z;
                        end
                    end
                    byte_alu_pkg::OP_WORD_ADD_IMM,
                    byte_alu_pkg::OP_WORD_MINUS_IMM: begin
                        ar = arith8(s_q.dest, wordImm, 1'b0,
                            s_q.op == byte_alu_pkg::OP_WORD_MINUS_IMM);
                        s_d.wCarry   = ar.c;
                        s_d.wLowZero = (ar.res == byte_alu_pkg::BYTE_ZERO);
                        s_d.phase    = byte_alu_pkg::PH_WORD_HI;
                    end
                    byte_alu_pkg::OP_AND, byte_alu_pkg::OP_AND_IMM: begin
                        ar.res = s_q.dest & ((s_q.op == byte_alu_pkg::OP_AND)
                            ? s_q.src : s_q.imm);
                        f = znvs(s_q.flags, ar.res, 1'b0);
                    end
                    byte_alu_pkg::OP_OR, byte_alu_pkg::OP_OR_IMM,
                    byte_alu_pkg::OP_MASK_SET: begin
                        ar.res = s_q.dest | ((s_q.op == byte_alu_pkg::OP_OR)
                            ? s_q.src : s_q.imm);
                        f = znvs(s_q.flags, ar.res, 1'b0);
                    end
                    byte_alu_pkg::OP_XOR: begin
                        ar.res = s_q.dest ^ s_q.src;
                        f = znvs(s_q.flags, ar.res, 1'b0);
                    end
                    byte_alu_pkg::OP_MASK_CLEAR: begin
                        ar.res = s_q.dest
                            & (byte_alu_pkg::BYTE_ALL_ONES - s_q.imm);
                        f = znvs(s_q.flags, ar.res, 1'b0);
                    end
                    byte_alu_pkg::OP_COMPLEMENT: begin
                        ar.res = byte_alu_pkg::BYTE_ALL_ONES - s_q.dest;
                        f   = znvs(s_q.flags, ar.res, 1'b0);
                        f.c = 1'b1;
                    end
                    byte_alu_pkg::OP_TWOS_COMPLEMENT: begin
                        ar = arith8(byte_alu_pkg::BYTE_ZERO, s_q.dest,
                            1'b0, 1'b1);
                        f   = znvs(s_q.flags, ar.res, ar.v);
                        f.c = ar.c;
                        f.h = ar.h;
                    end
                    byte_alu_pkg::OP_PLUS_ONE,
                    byte_alu_pkg::OP_MINUS_ONE: begin
                        ar = arith8(s_q.dest, byte_alu_pkg::BYTE_ONE, 1'b0,
                            s_q.op == byte_alu_pkg::OP_MINUS_ONE);
                        f = znvs(s_q.flags, ar.res, ar.v);
                    end
                endcase
                s_d.dest  = ar.res;
                s_d.flags = f;
            end
            byte_alu_pkg::PH_WORD_HI: begin
                // second cycle: high byte takes the low byte's carry
                ar = arith8(s_q.wordHi, byte_alu_pkg::BYTE_ZERO, s_q.wCarry,
                    s_q.op == byte_alu_pkg::OP_WORD_MINUS_IMM);
                f     = znvs(s_q.flags, ar.res, ar.v);
                f.z   = f.z && s_q.wLowZero;
                f.c   = ar.c;
                s_d.wordHi = ar.res;
                s_d.flags  = f;
                s_d.phase  = byte_alu_pkg::PH_IDLE;
            end
            default: s_d.phase = byte_alu_pkg::PH_IDLE;
        endcase

        // bus: write data phase, ignored while an operation runs
        if (s_q.wPend && !busy) begin
            unique case (s_q.wAddr)
                byte_alu_pkg::REG_DEST:    s_d.dest   = wByte;
                byte_alu_pkg::REG_SRC:     s_d.src    = wByte;
                byte_alu_pkg::REG_IMM:     s_d.imm    = wByte;
                byte_alu_pkg::REG_WORD_HI: s_d.wordHi = wByte;
                byte_alu_pkg::REG_FLAGS:
                    s_d.flags = hwdata[byte_alu_pkg::FLAG_W-1:0];
                byte_alu_pkg::REG_CMD: begin
                    if (hwdata[byte_alu_pkg::OP_W-1:0]
                        <= byte_alu_pkg::OP_LAST) begin
                        s_d.op = byte_alu_pkg::opcode_t'(
                            hwdata[byte_alu_pkg::OP_W-1:0]);
                        s_d.phase = byte_alu_pkg::PH_EXEC;
                    end
                end
                default: begin
                end
            endcase
        end

        s_d.resp = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q <= RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs taken straight from the state flip-flops
    assign hrdata    = s_q.rdata;
    assign hreadyout = s_q.ready;
    assign hresp     = s_q.resp;

endmodule

// *** verif/alu_bus_checker.sv ***
// bus-side assertions for the byte arithmetic unit
// assumes: bound into byte_arith_logic_unit, hready tied to hreadyout
`timescale 1ns/100ps
module alu_bus_checker #(
    parameter int unsigned WORD_IMM_W = 6
) (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    sequence readAcc;
        hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
    endsequence
    sequence writeAcc;
        hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
    endsequence
    sequence readBeat;
        !hreadyout ##1 hreadyout;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_read_wait: assert property (readAcc |=> readBeat)
        else $error("read wait state wrong");
    a_write_nowait: assert property (writeAcc |=> hreadyout)
        else $error("write stalled");
    a_wait_single: assert property (!hreadyout |=> hreadyout)
        else $error("wait longer than one cycle");
    a_low_cause: assert property ($fell(hreadyout) |->
        $past(hsel && hready && htrans[1] && !hwrite && hsize == 3'h2))
        else $error("wait without read");
    a_rdata_hold: assert property (!$stable(hrdata) |-> $rose(hreadyout))
        else $error("read data moved outside read end");
    a_flags_upper: assert property (readAcc ##0
        haddr[7:0] == byte_alu_pkg::REG_FLAGS |=> ##1 hrdata[31:6] == '0)
        else $error("flag read upper bits set");
    a_unmapped_zero: assert property (readAcc ##0
        (haddr[7:0] > byte_alu_pkg::REG_CMD || haddr[1:0] != 2'h0)
        |=> ##1 hrdata == '0)
        else $error("unmapped read not zero");
    a_byte_upper: assert property (readAcc ##0 haddr[1:0] == 2'h0 &&
        haddr[7:0] <= byte_alu_pkg::REG_WORD_HI |=> ##1 hrdata[31:8] == '0)
        else $error("byte register upper bits set");
endmodule
bind byte_arith_logic_unit alu_bus_checker #(.WORD_IMM_W(WORD_IMM_W))
    u_alu_bus_checker (
    .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));

// *** verif/byte_arith_logic_unit_test.sv ***
// self-checking bench for the byte arithmetic unit
// assumes: core_bus_model drives the bus, checker bound separately
`timescale 1ns/100ps
module byte_arith_logic_unit_test;
    logic        mclk;
    logic        rstn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] x;
    int          n_fail;
    int          cmp_count;

    byte_arith_logic_unit #(.WORD_IMM_W(6)) u_byte_arith_logic_unit (
        .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp));
    core_bus_model u_core_bus_model (
        .mclk(mclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    // result {high, low} and flags {H,S,V,N,Z,C}
    function automatic logic [21:0] expect_op(input logic [4:0] op,
        input logic [7:0] d, s, k, hi, input logic [5:0] f);
        logic [8:0]  t;
        logic [4:0]  h;
        logic [15:0] w;
        logic [15:0] q;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  r;
        logic        sb;
        logic        ci;
        logic        c;
        logic        hc;
        logic        v;
        logic        n;
        logic        z;
        logic        wd;
        w = {hi, d};
        wd = op inside {5'h06, 5'h07};
        sb = op inside {[5'h02:5'h05], 5'h0E};
        ci = (op inside {5'h01, 5'h03, 5'h05}) & f[0];
        a = (op == 5'h0E) ? 8'h00 : d;
        b = (op inside {5'h04, 5'h05}) ? k : ((op == 5'h0E) ? d : s);
        t = sb ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
        h = sb ? {1'b0, a[3:0]} - b[3:0] - ci : {1'b0, a[3:0]} + b[3:0] + ci;
        r = t[7:0];
        c = t[8];
        hc = h[4];
        v = (a[7] ^ b[7] ^ ~sb) & (r[7] ^ a[7]);
        if (!(op inside {[5'h00:5'h05], 5'h0E})) begin
            c = (op == 5'h0D) | f[0];
            hc = f[5];
            v = 1'b0;
        end
        case (op)
            5'h08: r = d & s;
            5'h09: r = d & k;
            5'h0A: r = d | s;
            5'h0B, 5'h0F: r = d | k;
            5'h0C: r = d ^ s;
            5'h0D: r = ~d;
            5'h10: r = d & (8'hFF - k);
            5'h11: r = d + 8'h01;
            5'h12: r = d - 8'h01;
            default: ;
        endcase
        if (op inside {5'h11, 5'h12})
            v = (r == ((op == 5'h11) ? 8'h80 : 8'h7F));
        q = (op == 5'h06) ? w + {10'h000, k[5:0]} :
            (op == 5'h07) ? w - {10'h000, k[5:0]} : {hi, r};
        if (wd) begin
            c = (op == 5'h06) ? (w[15] & ~q[15]) : (q[15] & ~w[15]);
            v = (op == 5'h06) ? (~w[15] & q[15]) : (w[15] & ~q[15]);
        end
        z = wd ? (q == 16'h0000) : (q[7:0] == 8'h00);
        z = z & ((op inside {5'h03, 5'h05}) ? f[1] : 1'b1);
        n = wd ? q[15] : q[7];
        return {q, hc, n ^ v, v, n, z, c};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [2:0] sz = 3'h2);
        logic [31:0] y;
        u_core_bus_model.xfer(1'b1, a, sz, {24'h00_0000, d}, y);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] y);
        u_core_bus_model.xfer(1'b0, a, 3'h2, 32'h0000_0000, y);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    task automatic run_op(input logic [4:0] op, input logic [7:0] d, s, k,
                          hi, input logic [5:0] f);
        logic [21:0] e;
        int          n;
        e = expect_op(op, d, s, k, hi, f);
        wr(byte_alu_pkg::REG_DEST, d);
        wr(byte_alu_pkg::REG_SRC, s);
        wr(byte_alu_pkg::REG_IMM, k);
        wr(byte_alu_pkg::REG_WORD_HI, hi);
        wr(byte_alu_pkg::REG_FLAGS, {2'h0, f});
        wr(byte_alu_pkg::REG_CMD, {3'h0, op});
        n = 0;
        do begin
            rd(byte_alu_pkg::REG_CMD, x);
            n++;
        end while (x[8] !== 1'b0 && n < 8);
        chk(x, {27'h000_0000, op});
        rd(byte_alu_pkg::REG_DEST, x);
        chk(x, {24'h00_0000, e[13:6]});
        rd(byte_alu_pkg::REG_WORD_HI, x);
        chk(x, {24'h00_0000, e[21:14]});
        rd(byte_alu_pkg::REG_FLAGS, x);
        chk(x, {26'h000_0000, e[5:0]});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        void'($urandom(73));
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), x);
            chk(x, 32'h0000_0000);
        end
        $display("reset values test done");
        wr(8'h18, 8'h5A);
        rd(8'h18, x);
        chk(x, 32'h0000_0000);
        rd(8'h01, x);
        chk(x, 32'h0000_0000);
        wr(byte_alu_pkg::REG_DEST, 8'h3C, 3'h0);
        rd(byte_alu_pkg::REG_DEST, x);
        chk(x, 32'h0000_0000);
        $display("ignored access test done");
        for (int op = 0; op <= 18; op++) begin
            run_op(5'(op), 8'hFF, 8'h01, 8'h01, 8'hFF, 6'h3F);
            run_op(5'(op), 8'h80, 8'h01, 8'h01, 8'h00, 6'h00);
            run_op(5'(op), 8'h00, 8'h00, 8'h00, 8'h00, 6'h3F);
            for (int j = 0; j < 5; j++)
                run_op(5'(op), 8'($urandom), 8'($urandom), 8'($urandom),
                       8'($urandom), 6'($urandom));
        end
        $display("operation test done");
        rd(byte_alu_pkg::REG_DEST, x);
        wr(byte_alu_pkg::REG_CMD, 8'h13);
        rd(byte_alu_pkg::REG_CMD, x);
        chk(x, 32'h0000_0012);
        $display("illegal opcode test done");
        run_op(5'h06, 8'h10, 8'h00, 8'h01, 8'h20, 6'h00);
        wr(byte_alu_pkg::REG_CMD, 8'h06);
        wr(byte_alu_pkg::REG_DEST, 8'hAA);
        rd(byte_alu_pkg::REG_DEST, x);
        chk(x, 32'h0000_0012);
        $display("busy write test done");
        tally_and_finish();
    end
    initial begin
        repeat (30000) @(posedge mclk);
        n_fail++;
        tally_and_finish();
    end
endmodule

// *** verif/core_bus_model.sv ***
// bus master standing in for the core decoder and register file
// assumes: tasks entered just after a rising edge, one slave
`timescale 1ns/100ps
module core_bus_model (
    input  wire logic        mclk,
    input  wire logic        hreadyout,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end
    // one single transfer; returns just after the data edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [2:0] sz, input logic [31:0] wd,
                        output logic [31:0] rd);
        logic ok;
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= byte_alu_pkg::TRANS_NONSEQ;
        hwrite <= wr;
        hsize <= sz;
        // hready read mid-cycle, where it stands for the coming edge
        do begin
            @(negedge mclk);
            ok = hreadyout;
            @(posedge mclk);
        end while (ok !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~haddr;
        hwdata <= wr ? wd : ~hwdata;
        do begin
            @(negedge mclk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge mclk);
        end while (ok !== 1'b1);
    endtask
endmodule
